// file: core/sdam_pkg.sv
// Shared constants and types of the servo deviation and link alarm monitor.
package sdam_pkg;
    // Master clock rate in hertz.
    localparam int CLK_HZ = 20_000_000;
    // Largest position magnitude before the overflow alarm.
    localparam logic [32:0] POS_LIMIT = 33'h070000000;
    // Legal station address range.
    localparam logic [7:0] ADDR_MIN = 8'h03;
    localparam logic [7:0] ADDR_MAX = 8'hEF;
    // Supported transmission cycle range in microseconds.
    localparam logic [15:0] CYCLE_MIN_US = 16'h007D;
    localparam logic [15:0] CYCLE_MAX_US = 16'h0FA0;
    // Allowed cycle-to-cycle period change, in nanoseconds and in clocks.
    localparam int JITTER_NS = 2000;
    localparam int JITTER_CYC = JITTER_NS * (CLK_HZ / 1_000_000) / 1000;
    // One bit per data size switch value; a set bit marks a valid value.
    localparam logic [3:0] DSIZE_OK_MASK = 4'h3;
    // Good watchdog updates needed before synchronous operation starts.
    localparam logic [2:0] START_CYCLES = 3'h4;
    // Alarm bit positions.
    localparam int AL_DEV = 0;
    localparam int AL_SON = 1;
    localparam int AL_LIM = 2;
    localparam int AL_POS = 3;
    localparam int AL_ISYNC = 4;
    localparam int AL_CYC = 5;
    localparam int AL_DSIZE = 6;
    localparam int AL_ADDR = 7;
    localparam int AL_NSYNC = 8;
    localparam int AL_START = 9;
    localparam int NUM_ALARMS = 10;
    // Alarm codes reported to the host, indexed by alarm bit.
    localparam logic [7:0] ALARM_CODE [NUM_ALARMS] = '{8'h10, 8'h11, 8'h12, 8'h13,
        8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25};
    // Code shown while no alarm is pending.
    localparam logic [7:0] NO_ALARM_CODE = 8'h00;
    // Latched alarm flags, one per alarm bit.
    typedef logic [NUM_ALARMS-1:0] sdam_alarm_type;
    // Setting switches as read from the pins.
    typedef struct packed {
        logic [3:0] address_switch_high;
        logic [3:0] address_switch_low;
        logic [1:0] data_size_switch;
    } sdam_switch_type;
    // Speed limit settings applied at servo-on.
    typedef struct packed {
        logic [15:0] servo_on_speed_limit_a;
        logic [15:0] servo_on_speed_limit_b;
        logic select_b;
    } sdam_limit_type;
    // Synchronous communication states.
    typedef enum {SYNC_IDLE, SYNC_CHECK, SYNC_RUN} sdam_sync_state_type;
endpackage

// file: core/sdam_sync.sv
// Two-stage synchroniser for pin inputs.
`timescale 1ns/1ns
module sdam_sync #(
    parameter int WIDTH = 1
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    // First stage, read only by the second stage.
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_sync_out;

    // Next values simply shift the pin level along.
    always_comb begin
        next_stage1 = async_in;
        next_sync_out = stage1;
    end

    // Registers clear on reset so logic sees a defined level.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= next_stage1;
            sync_out <= next_sync_out;
        end
    end
endmodule

// file: core/sdam_cycle_meter.sv
// Measures the network cycle period and flags fluctuation.
`timescale 1ns/1ns
module sdam_cycle_meter #(
    parameter int CNT_W = 20
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic cycle_tick,
    output logic fluctuated
);
    // Clocks since the last cycle start, saturating.
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    // Period of the previous cycle.
    logic [CNT_W-1:0] prev_period;
    logic [CNT_W-1:0] next_prev_period;
    // A first tick has been seen, and a full period has been measured.
    logic started;
    logic next_started;
    logic have_prev;
    logic next_have_prev;
    logic next_fluctuated;
    logic [CNT_W-1:0] diff;

    // Compares each new period with the last one.
    always_comb begin
        diff = (count > prev_period) ? count - prev_period : prev_period - count;
        next_count = (&count) ? count : count + 1'b1;
        next_prev_period = prev_period;
        next_started = started;
        next_have_prev = have_prev;
        next_fluctuated = 1'b0;
        if (cycle_tick) begin
            next_count = {{(CNT_W-1){1'b0}}, 1'b1};
            next_started = 1'b1;
            if (started) begin
                next_prev_period = count;
                next_have_prev = 1'b1;
                // A change larger than the tolerance is a fluctuation.
                next_fluctuated = have_prev && (diff > CNT_W'(sdam_pkg::JITTER_CYC));
            end
        end
    end

    // Registers the measurement state.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            count <= '0;
            prev_period <= '0;
            started <= 1'b0;
            have_prev <= 1'b0;
            fluctuated <= 1'b0;
        end else begin
            count <= next_count;
            prev_period <= next_prev_period;
            started <= next_started;
            have_prev <= next_have_prev;
            fluctuated <= next_fluctuated;
        end
    end

    fluct_flag_a: assert property (@(posedge mclk) disable iff (sys_rst)
        cycle_tick && have_prev && (diff > CNT_W'(sdam_pkg::JITTER_CYC)) |=> fluctuated)
        else $error("cycle fluctuation not flagged");
endmodule

// file: core/sdam_monitor.sv
// Deviation, position and network link alarm monitor, top level.
`timescale 1ns/1ns
module sdam_monitor (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic servo_on,
    input wire logic signed [31:0] deviation,
    input wire logic signed [31:0] position,
    input wire logic position_ref_valid,
    input wire logic [31:0] deviation_overflow_level,
    input wire logic [31:0] servo_on_deviation_overflow_level,
    input wire sdam_pkg::sdam_limit_type limit_cfg,
    input wire logic signed [15:0] speed_command,
    input wire logic cycle_pulse,
    input wire logic [15:0] cycle_setting_us,
    input wire sdam_pkg::sdam_switch_type switches,
    input wire logic duplicate_address_seen,
    input wire logic [7:0] host_watchdog_data,
    input wire logic sync_start_req,
    input wire logic alarm_clear,
    output sdam_pkg::sdam_alarm_type alarms,
    output logic [7:0] alarm_code,
    output logic signed [15:0] speed_limited,
    output logic speed_limit_active,
    output logic sync_running
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);

    // Synchronised switch levels and cycle marker.
    sdam_pkg::sdam_switch_type sw;
    logic cycle_sync;
    // Previous cycle marker level for edge detection.
    logic cycle_prev;
    logic next_cycle_prev;
    // One-cycle pulse at each network cycle start.
    logic cycle_tick;
    // Fluctuation pulse from the period meter.
    logic fluct;

    sdam_sync #(.WIDTH(11)) i_sdam_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .async_in({switches, cycle_pulse}),
        .sync_out({sw, cycle_sync})
    );

    sdam_cycle_meter #(.CNT_W(20)) i_sdam_cycle_meter (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .cycle_tick(cycle_tick),
        .fluctuated(fluct)
    );

    // Magnitude of a signed word, one bit wider so the most negative fits.
    function automatic logic [32:0] mag(input logic signed [31:0] v);
        logic [32:0] w;
        w = {v[31], v};
        return v[31] ? (~w + 33'h000000001) : w;
    endfunction

    // Servo and deviation state.
    logic servo_prev;
    logic next_servo_prev;
    logic servo_rise;
    logic [32:0] dev_mag;
    logic dev_nonzero;
    logic dev_over;
    // Deviation exceeded the servo-on level while the servo was off.
    logic son_armed;
    logic next_son_armed;
    // A position reference arrived during the limited condition.
    logic ref_seen;
    logic next_ref_seen;
    logic next_speed_limit_active;
    logic signed [15:0] next_speed_limited;
    logic signed [16:0] lim;

    // Link state.
    sdam_pkg::sdam_sync_state_type state;
    sdam_pkg::sdam_sync_state_type next_state;
    logic [2:0] good_count;
    logic [2:0] next_good_count;
    logic [7:0] last_wd;
    logic [7:0] next_last_wd;
    logic wd_changed;
    logic [7:0] station_address;

    // Alarm events and latch.
    sdam_pkg::sdam_alarm_type events;
    sdam_pkg::sdam_alarm_type next_alarms;
    logic [7:0] next_alarm_code;

    // Edge detection on the synchronised cycle marker and on servo-on.
    always_comb begin
        next_cycle_prev = cycle_sync;
        cycle_tick = cycle_sync && !cycle_prev;
        next_servo_prev = servo_on;
        servo_rise = servo_on && !servo_prev;
        dev_mag = mag(deviation);
        dev_nonzero = deviation != 32'sh00000000;
        dev_over = dev_mag > {1'b0, deviation_overflow_level};
        wd_changed = host_watchdog_data != last_wd;
        station_address = {sw.address_switch_high, sw.address_switch_low};
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cycle_prev <= 1'b0;
            servo_prev <= 1'b0;
        end else begin
            cycle_prev <= next_cycle_prev;
            servo_prev <= next_servo_prev;
        end
    end

    // Servo-on arming, speed limit condition and speed clamp.
    always_comb begin
        next_son_armed = son_armed;
        next_speed_limit_active = speed_limit_active;
        next_ref_seen = ref_seen;
        lim = limit_cfg.select_b ? {1'b0, limit_cfg.servo_on_speed_limit_b}
                                 : {1'b0, limit_cfg.servo_on_speed_limit_a};
        if (!servo_on) begin
            // Track whether the deviation is above the servo-on level on each clock while the servo is off.
            next_son_armed = mag(deviation) > {1'b0, servo_on_deviation_overflow_level};
            next_speed_limit_active = 1'b0;
            next_ref_seen = 1'b0;
        end else if (servo_rise) begin
            // Deviation left in the counter at servo-on starts the limit.
            next_speed_limit_active = dev_nonzero;
            next_ref_seen = 1'b0;
            next_son_armed = 1'b0;
        end else if (speed_limit_active) begin
            // The limit ends once the deviation has been worked off.
            next_speed_limit_active = dev_nonzero;
            next_ref_seen = ref_seen || position_ref_valid;
        end
        next_speed_limited = speed_command;
        if (speed_limit_active) begin
            if (17'(speed_command) > lim) begin
                next_speed_limited = lim[15:0];
            end else if (17'(speed_command) < -lim) begin
                next_speed_limited = 16'(-lim);
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            son_armed <= 1'b0;
            speed_limit_active <= 1'b0;
            ref_seen <= 1'b0;
            speed_limited <= 16'sh0000;
        end else begin
            son_armed <= next_son_armed;
            speed_limit_active <= next_speed_limit_active;
            ref_seen <= next_ref_seen;
            speed_limited <= next_speed_limited;
        end
    end

    // Synchronous communication start and watchdog supervision.
    always_comb begin
        next_state = state;
        next_good_count = good_count;
        next_last_wd = cycle_tick ? host_watchdog_data : last_wd;
        unique case (state)
            sdam_pkg::SYNC_IDLE: begin
                if (sync_start_req) begin
                    next_state = sdam_pkg::SYNC_CHECK;
                    next_good_count = 3'h0;
                end
            end
            sdam_pkg::SYNC_CHECK: begin
                if (cycle_tick) begin
                    if (!wd_changed) begin
                        // Stale watchdog at start: stay out of sync.
                        next_state = sdam_pkg::SYNC_IDLE;
                    end else if (good_count == sdam_pkg::START_CYCLES - 3'h1) begin
                        next_state = sdam_pkg::SYNC_RUN;
                    end else begin
                        next_good_count = good_count + 3'h1;
                    end
                end
            end
            sdam_pkg::SYNC_RUN: begin
                if (cycle_tick && !wd_changed) begin
                    // Synchronous operation stops on a missed update.
                    next_state = sdam_pkg::SYNC_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state <= sdam_pkg::SYNC_IDLE;
            good_count <= 3'h0;
            last_wd <= 8'h00;
            sync_running <= 1'b0;
        end else begin
            state <= next_state;
            good_count <= next_good_count;
            last_wd <= next_last_wd;
            sync_running <= next_state == sdam_pkg::SYNC_RUN;
        end
    end

    // Detected events, latched until cleared; a new event beats the clear.
    always_comb begin
        events = '0;
        events[sdam_pkg::AL_DEV] = servo_on && !speed_limit_active && dev_over;
        events[sdam_pkg::AL_SON] = servo_rise && son_armed;
        events[sdam_pkg::AL_LIM] = speed_limit_active && ref_seen && dev_over;
        events[sdam_pkg::AL_POS] = mag(position) > sdam_pkg::POS_LIMIT;
        events[sdam_pkg::AL_ISYNC] = fluct;
        events[sdam_pkg::AL_CYC] = (cycle_setting_us < sdam_pkg::CYCLE_MIN_US)
                                   || (cycle_setting_us > sdam_pkg::CYCLE_MAX_US);
        events[sdam_pkg::AL_DSIZE] = !sdam_pkg::DSIZE_OK_MASK[sw.data_size_switch];
        events[sdam_pkg::AL_ADDR] = (station_address < sdam_pkg::ADDR_MIN)
                                    || (station_address > sdam_pkg::ADDR_MAX)
                                    || duplicate_address_seen;
        events[sdam_pkg::AL_NSYNC] = (state == sdam_pkg::SYNC_RUN) && cycle_tick && !wd_changed;
        events[sdam_pkg::AL_START] = (state == sdam_pkg::SYNC_CHECK) && cycle_tick && !wd_changed;
        next_alarms = (alarm_clear ? '0 : alarms) | events;
        // The lowest pending alarm bit names the reported code.
        next_alarm_code = sdam_pkg::NO_ALARM_CODE;
        for (int i = sdam_pkg::NUM_ALARMS - 1; i >= 0; i--) begin
            if (next_alarms[i]) begin
                next_alarm_code = sdam_pkg::ALARM_CODE[i];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            alarms <= '0;
            alarm_code <= 8'h00;
        end else begin
            alarms <= next_alarms;
            alarm_code <= next_alarm_code;
        end
    end

    // Steps of a failed synchronous start.
    sequence start_check_s;
        state == sdam_pkg::SYNC_CHECK;
    endsequence
    sequence stale_tick_s;
        cycle_tick && !wd_changed;
    endsequence

    dev_overflow_a: assert property (servo_on && !speed_limit_active && dev_over |=> alarms[sdam_pkg::AL_DEV])
        else $error("deviation overflow alarm missing");
    son_deviation_a: assert property (servo_rise && son_armed |=> alarms[sdam_pkg::AL_SON])
        else $error("servo-on deviation alarm missing");
    limit_entry_a: assert property (servo_on && !servo_prev && dev_nonzero |=> speed_limit_active)
        else $error("speed limit not entered at servo-on");
    speed_clamp_a: assert property (speed_limit_active |=> 17'(speed_limited) <= $past(lim))
        else $error("speed exceeds servo-on limit");
    limit_deviation_a: assert property (speed_limit_active && ref_seen && dev_over |=> alarms[sdam_pkg::AL_LIM])
        else $error("speed limit deviation alarm missing");
    pos_overflow_a: assert property (mag(position) > sdam_pkg::POS_LIMIT |=> alarms[sdam_pkg::AL_POS])
        else $error("position overflow alarm missing");
    addr_range_a: assert property (station_address > sdam_pkg::ADDR_MAX |=> alarms[sdam_pkg::AL_ADDR])
        else $error("station address error missing");
    start_fail_a: assert property (start_check_s and stale_tick_s |=> alarms[sdam_pkg::AL_START] && !sync_running)
        else $error("stale watchdog at start not caught");
    wd_stale_a: assert property (sync_running ##0 stale_tick_s |=> alarms[sdam_pkg::AL_NSYNC] && !sync_running)
        else $error("watchdog stall not caught");
    alarm_hold_a: assert property (!alarm_clear |=> (alarms & $past(alarms)) == $past(alarms))
        else $error("latched alarm dropped without clear");
endmodule

// file: bench/sdam_host_model.sv
// Behavioural host controller model: network cycle marker and watchdog byte.
`timescale 1ns/1ns
module sdam_host_model (
    input wire logic mclk,
    input wire logic enable,
    input wire logic stale,
    input wire logic [7:0] period,
    input wire logic [7:0] jitter,
    output logic cycle_pulse,
    output logic [7:0] host_watchdog_data
);
    // Clocks since the last cycle start.
    logic [8:0] count = 9'h000;
    // Selects the longer period on every other cycle, so a non-zero jitter makes the period wobble.
    logic long_next = 1'b0;
    // The marker idles low and the byte starts at zero.
    initial begin
        cycle_pulse = 1'b0;
        host_watchdog_data = 8'h00;
    end
    // Each cycle start raises the marker for four clocks and renews the watchdog byte unless told to stall.
    always @(posedge mclk) begin
        if (!enable) begin
            // The marker stands still while the host is not cycling.
            count <= 9'h000;
            cycle_pulse <= 1'b0;
        end else if (count >= {1'b0, period} + (long_next ? {1'b0, jitter} : 9'h000)) begin
            count <= 9'h000;
            cycle_pulse <= 1'b1;
            long_next <= !long_next;
            if (!stale) begin
                // A fresh watchdog value in every cycle; a stall is only ever commanded by the bench.
                host_watchdog_data <= host_watchdog_data + 8'h01;
            end
        end else begin
            count <= count + 9'h001;
            if (count == 9'h003) begin
                cycle_pulse <= 1'b0;
            end
        end
    end
endmodule

// file: bench/sdam_monitor_tb.sv
// Self-checking testbench of the deviation and link alarm monitor.
`timescale 1ns/1ns
module sdam_monitor_tb;
    // One table row: inputs and the latched alarms they should give.
    typedef struct packed {
        logic [31:0] dev;
        logic [31:0] pos;
        logic [15:0] cyc;
        sdam_pkg::sdam_switch_type sw;
        sdam_pkg::sdam_alarm_type exp;
    } sdam_row_type;
    sdam_row_type rows [19];
    // Design inputs, all given a value at time zero.
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic servo_on = 1'b1;
    logic signed [31:0] deviation = 32'h00000000;
    logic signed [31:0] position = 32'h00000000;
    logic position_ref_valid = 1'b0;
    logic [31:0] deviation_overflow_level = 32'h000003E8;
    logic [31:0] servo_on_deviation_overflow_level = 32'h000001F4;
    sdam_pkg::sdam_limit_type limit_cfg = '{16'h0100, 16'h0080, 1'b0};
    logic signed [15:0] speed_command = 16'h0000;
    logic cycle_pulse;
    logic [15:0] cycle_setting_us = 16'h03E8;
    sdam_pkg::sdam_switch_type switches = 10'h040;
    logic duplicate_address_seen = 1'b0;
    logic [7:0] host_watchdog_data;
    logic sync_start_req = 1'b0;
    logic alarm_clear = 1'b0;
    // Host model controls.
    logic host_en = 1'b0;
    logic host_stale = 1'b0;
    logic [7:0] host_jitter = 8'h00;
    // Design outputs.
    sdam_pkg::sdam_alarm_type alarms;
    logic [7:0] alarm_code;
    logic signed [15:0] speed_limited;
    logic speed_limit_active;
    logic sync_running;
    // Mismatch and comparison counters.
    int errors = 0;
    int tests_run = 0;

    // The 20 MHz clock.
    initial begin
        forever #25 mclk = ~mclk;
    end

    sdam_host_model i_sdam_host_model (.mclk(mclk), .enable(host_en), .stale(host_stale), .period(8'h3C),
        .jitter(host_jitter), .cycle_pulse(cycle_pulse), .host_watchdog_data(host_watchdog_data));

    sdam_monitor i_sdam_monitor (.mclk(mclk), .sys_rst(sys_rst), .servo_on(servo_on), .deviation(deviation),
        .position(position), .position_ref_valid(position_ref_valid),
        .deviation_overflow_level(deviation_overflow_level),
        .servo_on_deviation_overflow_level(servo_on_deviation_overflow_level), .limit_cfg(limit_cfg),
        .speed_command(speed_command), .cycle_pulse(cycle_pulse), .cycle_setting_us(cycle_setting_us),
        .switches(switches), .duplicate_address_seen(duplicate_address_seen),
        .host_watchdog_data(host_watchdog_data), .sync_start_req(sync_start_req), .alarm_clear(alarm_clear),
        .alarms(alarms), .alarm_code(alarm_code), .speed_limited(speed_limited),
        .speed_limit_active(speed_limit_active), .sync_running(sync_running));

    // Counts a comparison and reports a mismatch.
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Waits a number of falling edges, where inputs change and outputs are settled.
    task automatic ticks(input int n);
        repeat (n) @(negedge mclk);
    endtask

    // Pulses the alarm clear for one clock.
    task automatic clear_alarms;
        alarm_clear = 1'b1;
        ticks(1);
        alarm_clear = 1'b0;
        ticks(2);
    endtask

    // Code of the lowest set alarm bit, or the idle code.
    function automatic logic [7:0] code_of(input sdam_pkg::sdam_alarm_type a);
        for (int k = 0; k < sdam_pkg::NUM_ALARMS; k++) begin
            if (a[k]) begin
                return sdam_pkg::ALARM_CODE[k];
            end
        end
        return sdam_pkg::NO_ALARM_CODE;
    endfunction

    // Prints the counts and the verdict, then ends the run.
    task automatic close_out;
        $display("Counts: %0d comparisons, %0d mismatches", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Bounded wait for an alarm bit (0 to 9) or the sync running flag (10) to reach a level.
    task automatic wait_sig(input int sel, input logic val, input int limit);
        int n;
        n = 0;
        while (((sel < 10) ? alarms[sel] : sync_running) !== val && n < limit) begin
            ticks(1);
            n++;
        end
        if (n >= limit) begin
            errors++;
            $display("ERROR wait on signal %0d for level %b ran out", sel, val);
            close_out();
        end
    endtask

    // Main sequence.
    initial begin
        rows = '{
            '{32'h00000000, 32'h00000000, 16'h03E8, 10'h040, 10'h000},
            '{32'h000003E9, 32'h00000000, 16'h03E8, 10'h040, 10'h001},
            '{32'h000003E8, 32'h00000000, 16'h03E8, 10'h040, 10'h000},
            '{32'hFFFFFC17, 32'h00000000, 16'h03E8, 10'h040, 10'h001},
            '{32'h00000000, 32'h70000001, 16'h03E8, 10'h040, 10'h008},
            '{32'h00000000, 32'h70000000, 16'h03E8, 10'h040, 10'h000},
            '{32'h00000000, 32'h8FFFFFFF, 16'h03E8, 10'h040, 10'h008},
            '{32'h00000000, 32'h00000000, 16'h007C, 10'h040, 10'h020},
            '{32'h00000000, 32'h00000000, 16'h007D, 10'h040, 10'h000},
            '{32'h00000000, 32'h00000000, 16'h0FA0, 10'h040, 10'h000},
            '{32'h00000000, 32'h00000000, 16'h0FA1, 10'h040, 10'h020},
            '{32'h00000000, 32'h00000000, 16'h03E8, 10'h042, 10'h040},
            '{32'h00000000, 32'h00000000, 16'h03E8, 10'h043, 10'h040},
            '{32'h00000000, 32'h00000000, 16'h03E8, 10'h041, 10'h000},
            '{32'h00000000, 32'h00000000, 16'h03E8, 10'h008, 10'h080},
            '{32'h00000000, 32'h00000000, 16'h03E8, 10'h00C, 10'h000},
            '{32'h00000000, 32'h00000000, 16'h03E8, 10'h3BC, 10'h000},
            '{32'h00000000, 32'h00000000, 16'h03E8, 10'h3C0, 10'h080},
            '{32'h000003E9, 32'h00000000, 16'h03E8, 10'h3C0, 10'h081}};
        // Reset for 12 clocks; every output must be idle.
        ticks(12);
        check("alarms in reset", 32'(alarms), 32'h00000000);
        check("outputs in reset", {speed_limited, alarm_code, 6'h00, speed_limit_active, sync_running}, 32'h0);
        sys_rst = 1'b0;
        ticks(3);
        clear_alarms();
        $display("Reset test done");
        // Table of level conditions, each checked after a clear.
        for (int i = 0; i < 19; i++) begin
            deviation = rows[i].dev;
            position = rows[i].pos;
            cycle_setting_us = rows[i].cyc;
            switches = rows[i].sw;
            ticks(5);
            clear_alarms();
            ticks(2);
            check("alarms", 32'(alarms), 32'(rows[i].exp));
            check("alarm_code", 32'(alarm_code), 32'(code_of(rows[i].exp)));
        end
        $display("Table test done");
        // Servo turned on with deviation above the servo-on level but below the normal level.
        servo_on = 1'b0;
        deviation = 32'h00000258;
        switches = 10'h040;
        ticks(3);
        clear_alarms();
        servo_on = 1'b1;
        speed_command = 16'h0300;
        ticks(3);
        check("servo-on alarm", 32'(alarms), 32'h002);
        check("limit active", 32'(speed_limit_active), 32'h1);
        check("limit a", 32'(speed_limited), 32'h0100);
        limit_cfg.select_b = 1'b1;
        ticks(3);
        check("limit b", 32'(speed_limited), 32'h0080);
        speed_command = 16'hFD00;
        ticks(3);
        check("limit b negative", 32'(speed_limited), 32'hFFFFFF80);
        check("servo-on alarm held", 32'(alarms), 32'h002);
        clear_alarms();
        deviation = 32'h000003E9;
        ticks(4);
        check("no reference yet", 32'(alarms), 32'h000);
        position_ref_valid = 1'b1;
        ticks(1);
        position_ref_valid = 1'b0;
        ticks(3);
        check("limited overflow", 32'(alarms), 32'h004);
        check("limited code", 32'(alarm_code), 32'(code_of(10'h004)));
        deviation = 32'h00000000;
        ticks(3);
        check("limit released", 32'(speed_limit_active), 32'h0);
        check("unclamped speed", 32'(speed_limited), 32'hFFFFFD00);
        check("limited alarm held", 32'(alarms), 32'h004);
        clear_alarms();
        check("cleared", 32'(alarms), 32'h000);
        $display("Servo-on test done");
        // A duplicate address report latches the address error.
        duplicate_address_seen = 1'b1;
        ticks(1);
        duplicate_address_seen = 1'b0;
        ticks(5);
        check("duplicate address", 32'(alarms), 32'h080);
        clear_alarms();
        $display("Duplicate address test done");
        // Host updating correctly: synchronous operation starts, then a stall breaks it.
        host_en = 1'b1;
        ticks(300);
        clear_alarms();
        sync_start_req = 1'b1;
        ticks(1);
        sync_start_req = 1'b0;
        wait_sig(10, 1'b1, 1000);
        check("clean start", 32'(alarms), 32'h000);
        host_stale = 1'b1;
        wait_sig(10, 1'b0, 300);
        ticks(1);
        check("watchdog stall", 32'(alarms), 32'h100);
        $display("Sync run test done");
        // Start requested while the watchdog is stale: the start fails.
        clear_alarms();
        sync_start_req = 1'b1;
        ticks(1);
        sync_start_req = 1'b0;
        wait_sig(9, 1'b1, 300);
        ticks(1);
        check("start failed", 32'(alarms), 32'h200);
        check("not running", 32'(sync_running), 32'h0);
        $display("Sync start failure test done");
        // Period wobble at the allowed limit, then one clock past it.
        clear_alarms();
        host_jitter = 8'h28;
        ticks(1200);
        check("wobble at limit", 32'(alarms), 32'h000);
        host_jitter = 8'h29;
        wait_sig(4, 1'b1, 1200);
        check("cycle fluctuation", 32'(alarms[4]), 32'h1);
        $display("Cycle fluctuation test done");
        // A reset in mid-run drops every latched alarm.
        sys_rst = 1'b1;
        ticks(2);
        check("alarms after reset", 32'(alarms), 32'h000);
        sys_rst = 1'b0;
        ticks(3);
        $display("Mid-run reset test done");
        close_out();
    end
endmodule
